// [dpa_pkg.sv]
// Purpose: constants, timing and pin bundle for the dual-port RAM host
// Assumes: 100 MHz mclk; host drives the left port of the memory
// Notes:   all figures in ns are converted to whole clock cycles here
package dpa_pkg;

    // ----------------------------------------------------------------
    // Clock and port timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACCESS_NS = 20;
    localparam int FLOWTHROUGH_DELAY_NS = 25;
    localparam int BUSY_SETTLE_NS = 20;
    localparam int WRITE_PULSE_NS = 20;
    localparam int SEMAPHORE_RECOVERY_TIME_NS = 15;
    localparam int SYNC_STAGES = 3;

    // Least times: round up, never below one cycle
    function automatic int cyclesUp(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [7:0] READ_CYC =
        8'(cyclesUp(ACCESS_NS + FLOWTHROUGH_DELAY_NS) + SYNC_STAGES);
    localparam logic [7:0] SETTLE_CYC =
        8'(cyclesUp(BUSY_SETTLE_NS) + SYNC_STAGES);
    localparam logic [7:0] WPULSE_CYC = 8'(cyclesUp(WRITE_PULSE_NS));
    localparam logic [7:0] RECOVER_CYC =
        8'(cyclesUp(SEMAPHORE_RECOVERY_TIME_NS));

    // ----------------------------------------------------------------
    // Pin widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int DATA_W = 36;
    localparam int LANES = 4;

    // ----------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_WDATA_HI = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [7:0] REG_RDATA_HI = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;

    localparam int CTRL_START = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_LANE_LSB = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_00F0;

    localparam int ST_ACTIVE = 0;
    localparam int ST_DONE = 1;
    localparam int ST_MAILBOX = 2;
    localparam int ST_BUSY_SEEN = 3;
    localparam int ST_TOKEN = 4;

    localparam logic [2:0] OP_MEM_RD = 3'h0;
    localparam logic [2:0] OP_MEM_WR = 3'h1;
    localparam logic [2:0] OP_SEM_RD = 3'h2;
    localparam logic [2:0] OP_SEM_WR = 3'h3;
    localparam logic [2:0] OP_SEM_GET = 3'h4;

    // ----------------------------------------------------------------
    // Pins driven toward the memory port (all selects active low)
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic chipEnableN;
        logic readWriteN;
        logic outputEnableN;
        logic tokenLatchSelectN;
        logic [LANES-1:0] byteLaneSelectsN;
        logic [DATA_W-1:0] dq;
        logic dqOeN;
    } dpa_pins_t;

    localparam dpa_pins_t PINS_IDLE = '{
        addr: '0, chipEnableN: 1'b1, readWriteN: 1'b1,
        outputEnableN: 1'b1, tokenLatchSelectN: 1'b1,
        byteLaneSelectsN: 4'hF, dq: '0, dqOeN: 1'b1};

endpackage

// [dpa_host_ctrl.sv]
// Purpose: host controller that drives one memory port and its semaphores
// Assumes: memory is asynchronous; every pin input is resynchronised
// Notes:   software orders one access at a time over a Wishbone slave
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module dpa_host_ctrl
    import dpa_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output dpa_pins_t pins,
    input wire logic [DATA_W-1:0] dqIn,
    input wire logic busyN,
    input wire logic mailboxIrqN
);

    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_STROBE, S_CAPTURE, S_RECOVER
    } dpa_state_t;

    // Byte-enable merge used by every writable register
    function automatic logic [31:0] mergeSel(input logic [31:0] oldV,
                                             input logic [31:0] newV,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = oldV;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = newV[i*8 +: 8];
            end
        end
        return r;
    endfunction

    dpa_state_t stateQ;
    logic [7:0] cntQ;
    logic [31:0] ctrlQ, addrQ, wdataQ, wdataHiQ;
    logic [DATA_W-1:0] rdataQ;
    logic ackQ, doneQ, busySeenQ, tokenQ, readPhaseQ;
    logic [2:0] opQ;
    logic [DATA_W-1:0] dqS1, dqS2, dqS3;
    logic [2:0] busyS, irqS;
    logic busyActQ, irqActQ;
    logic take, wbWrite, start, isMemOp, isWriteOp, dqSettled;

    // ----------------------------------------------------------------
    // Wishbone slave: one-cycle answer, every address acknowledged
    // ----------------------------------------------------------------
    assign take = wb_cyc_i && wb_stb_i && !ackQ;
    assign wbWrite = take && wb_we_i;
    assign wb_ack_o = ackQ;
    // A start while an access runs is dropped; status shows it is active
    assign start = wbWrite && wb_adr_i == REG_CTRL && wb_sel_i[0]
                   && wb_dat_i[CTRL_START] && stateQ == S_IDLE;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ackQ <= 1'b0;
        end else begin
            ackQ <= take;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrlQ <= CTRL_RESET;
            addrQ <= '0;
            wdataQ <= '0;
            wdataHiQ <= '0;
        end else if (wbWrite) begin
            unique case (wb_adr_i)
                REG_CTRL: ctrlQ <= mergeSel(ctrlQ, wb_dat_i, wb_sel_i);
                REG_ADDR: addrQ <= mergeSel(addrQ, wb_dat_i, wb_sel_i);
                REG_WDATA: wdataQ <= mergeSel(wdataQ, wb_dat_i, wb_sel_i);
                REG_WDATA_HI: begin
                    wdataHiQ <= mergeSel(wdataHiQ, wb_dat_i, wb_sel_i);
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (take) begin
            unique case (wb_adr_i)
                REG_CTRL: wb_dat_o <= {ctrlQ[31:1], 1'b0};
                REG_ADDR: wb_dat_o <= {18'h0, addrQ[ADDR_W-1:0]};
                REG_WDATA: wb_dat_o <= wdataQ;
                REG_WDATA_HI: wb_dat_o <= {28'h0, wdataHiQ[3:0]};
                REG_RDATA: wb_dat_o <= rdataQ[31:0];
                REG_RDATA_HI: wb_dat_o <= {28'h0, rdataQ[DATA_W-1:32]};
                REG_STATUS: begin
                    wb_dat_o <= '0;
                    wb_dat_o[ST_ACTIVE] <= stateQ != S_IDLE;
                    wb_dat_o[ST_DONE] <= doneQ;
                    wb_dat_o[ST_MAILBOX] <= irqActQ;
                    wb_dat_o[ST_BUSY_SEEN] <= busySeenQ;
                    wb_dat_o[ST_TOKEN] <= tokenQ;
                end
                default: wb_dat_o <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers: a change counts once stages two and three agree
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            dqS1 <= '0;
            dqS2 <= '0;
            dqS3 <= '0;
            busyS <= 3'h7;
            irqS <= 3'h7;
        end else begin
            dqS1 <= dqIn;
            dqS2 <= dqS1;
            dqS3 <= dqS2;
            busyS <= {busyS[1:0], busyN};
            irqS <= {irqS[1:0], mailboxIrqN};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            busyActQ <= 1'b0;
            irqActQ <= 1'b0;
        end else begin
            if (busyS[1] == busyS[2]) begin
                busyActQ <= !busyS[2];
            end
            if (irqS[1] == irqS[2]) begin
                irqActQ <= !irqS[2];
            end
        end
    end

    // ----------------------------------------------------------------
    // Access sequencer and port pins
    // ----------------------------------------------------------------
    assign isMemOp = opQ == OP_MEM_RD || opQ == OP_MEM_WR;
    assign isWriteOp = !readPhaseQ;
    // Only lane 0 carries a token value; the rest of the bus may move
    assign dqSettled = isMemOp ? dqS2 == dqS3
                       : dqS2[DATA_W/LANES-1:0] == dqS3[DATA_W/LANES-1:0];

    always_ff @(posedge mclk) begin
        if (rst) begin
            stateQ <= S_IDLE;
            cntQ <= '0;
            opQ <= OP_MEM_RD;
            readPhaseQ <= 1'b0;
            pins <= PINS_IDLE;
            rdataQ <= '0;
            doneQ <= 1'b0;
            busySeenQ <= 1'b0;
            tokenQ <= 1'b0;
        end else begin
            unique case (stateQ)
                S_IDLE: begin
                    if (start) begin
                        opQ <= wb_dat_i[CTRL_OP_LSB +: 3];
                        doneQ <= 1'b0;
                        busySeenQ <= 1'b0;
                        stateQ <= S_SETUP;
                        pins.addr <= addrQ[ADDR_W-1:0];
                        pins.readWriteN <= 1'b1;
                        unique case (wb_dat_i[CTRL_OP_LSB +: 3])
                            OP_MEM_RD: begin
                                pins.chipEnableN <= 1'b0;
                                pins.outputEnableN <= 1'b0;
                                pins.byteLaneSelectsN <=
                                    ~wb_dat_i[CTRL_LANE_LSB +: LANES];
                                readPhaseQ <= 1'b1;
                                cntQ <= READ_CYC;
                            end
                            OP_MEM_WR: begin
                                pins.chipEnableN <= 1'b0;
                                // Only lanes asked for are written
                                pins.byteLaneSelectsN <=
                                    ~wb_dat_i[CTRL_LANE_LSB +: LANES];
                                pins.dq <= {wdataHiQ[3:0], wdataQ};
                                pins.dqOeN <= 1'b0;
                                readPhaseQ <= 1'b0;
                                cntQ <= SETTLE_CYC;
                            end
                            OP_SEM_RD: begin
                                pins.tokenLatchSelectN <= 1'b0;
                                pins.outputEnableN <= 1'b0;
                                readPhaseQ <= 1'b1;
                                cntQ <= READ_CYC;
                            end
                            default: begin
                                // Request is a 0 on bit 0
                                pins.tokenLatchSelectN <= 1'b0;
                                pins.dq <= {35'h0,
                                    wb_dat_i[CTRL_OP_LSB +: 3] == OP_SEM_WR
                                    && wdataQ[0]};
                                pins.dqOeN <= 1'b0;
                                readPhaseQ <= 1'b0;
                                cntQ <= SETTLE_CYC;
                            end
                        endcase
                    end
                end
                S_SETUP: begin
                    if (cntQ > 8'h01) begin
                        cntQ <= cntQ - 8'h01;
                    end else if (isMemOp && busyActQ) begin
                        // Port lost arbitration: hold until it is free
                        busySeenQ <= 1'b1;
                    end else if (isWriteOp) begin
                        pins.readWriteN <= 1'b0;
                        cntQ <= WPULSE_CYC;
                        stateQ <= S_STROBE;
                    end else begin
                        stateQ <= S_CAPTURE;
                    end
                end
                S_STROBE: begin
                    if (cntQ > 8'h01) begin
                        cntQ <= cntQ - 8'h01;
                    end else begin
                        // Data is released on the same edge that raises the write strobe
                        pins.readWriteN <= 1'b1;
                        if (opQ == OP_SEM_GET) begin
                            // Select and OE go high first
                            pins.tokenLatchSelectN <= 1'b1;
                            pins.outputEnableN <= 1'b1;
                            pins.dqOeN <= 1'b1;
                            cntQ <= RECOVER_CYC;
                            stateQ <= S_RECOVER;
                        end else begin
                            pins <= PINS_IDLE;
                            doneQ <= 1'b1;
                            stateQ <= S_IDLE;
                        end
                    end
                end
                S_CAPTURE: begin
                    // Take the value only once the bus has stopped moving
                    if (dqSettled) begin
                        rdataQ <= dqS3;
                        if (!isMemOp) begin
                            tokenQ <= !dqS3[0];
                        end
                        if (opQ == OP_SEM_GET && dqS3[0]) begin
                            // Other port holds it: poll again
                            pins.tokenLatchSelectN <= 1'b1;
                            pins.outputEnableN <= 1'b1;
                            cntQ <= RECOVER_CYC;
                            stateQ <= S_RECOVER;
                        end else begin
                            pins <= PINS_IDLE;
                            doneQ <= 1'b1;
                            stateQ <= S_IDLE;
                        end
                    end
                end
                S_RECOVER: begin
                    if (cntQ > 8'h01) begin
                        cntQ <= cntQ - 8'h01;
                    end else begin
                        // Chip enable was never lowered here
                        pins.tokenLatchSelectN <= 1'b0;
                        pins.outputEnableN <= 1'b0;
                        readPhaseQ <= 1'b1;
                        cntQ <= READ_CYC;
                        stateQ <= S_SETUP;
                    end
                end
                default: begin
                    pins <= PINS_IDLE;
                    stateQ <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// [dpa_host_properties.sv]
// Purpose: port-level timing checks for the dual-port RAM host
// Assumes: bound to dpa_host_ctrl; single mclk domain
// Notes:   every select on the pin bundle is active low
`timescale 1ns/1ps

module dpa_host_properties
    import dpa_pkg::*;
(
    input logic mclk,
    input logic rst,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o,
    input dpa_pins_t pins,
    input logic busyN
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_answer: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    chk_reset_idle: assert property
        (disable iff (1'b0) rst |=> pins == PINS_IDLE)
        else $error("pins not idle after reset");
    chk_sem_ce_high: assert property
        (!pins.tokenLatchSelectN |-> pins.chipEnableN)
        else $error("chip enable low during token select");
    chk_sem_read: assert property
        (!pins.outputEnableN && !pins.tokenLatchSelectN
         |-> pins.chipEnableN && pins.readWriteN)
        else $error("token read without proper selects");
    chk_mem_read: assert property
        (!pins.outputEnableN && pins.tokenLatchSelectN |-> !pins.chipEnableN)
        else $error("output enable without chip enable");
    chk_write_drives: assert property
        (!pins.readWriteN |-> !pins.dqOeN && pins.outputEnableN)
        else $error("write pulse without driven data");
    chk_busy_hold: assert property
        (!busyN [*8] |-> !(!pins.readWriteN && !pins.chipEnableN
                           && $past(pins.readWriteN)))
        else $error("write started during busy");
    chk_sem_recover: assert property
        ($rose(pins.readWriteN) && !$past(pins.tokenLatchSelectN)
         |-> (pins.tokenLatchSelectN || pins.outputEnableN) [*2])
        else $error("token read back too soon");
    chk_addr_stable: assert property
        ((!pins.chipEnableN && !$past(pins.chipEnableN)) ||
         (!pins.tokenLatchSelectN && !$past(pins.tokenLatchSelectN))
         |-> $stable(pins.addr))
        else $error("address moved during access");
endmodule

// [dpa_dev_model.sv]
// Purpose: behavioural left-port model of the dual-port memory
// Assumes: sampled on mclk; right port is reduced to a few levers
// Notes:   undriven data shows a toggling pattern, never a held value
`timescale 1ns/1ps

module dpa_dev_model
    import dpa_pkg::*;
(
    input wire logic mclk,
    input dpa_pins_t pins,
    input wire logic busyForce,
    input wire logic rightMbxWr,
    input wire logic [7:0] rightHold,
    output logic [DATA_W-1:0] dqIn,
    output logic busyN,
    output logic mailboxIrqN,
    output logic rightIrqN
);
    // ------------------------------------------------------------
    // Array, token latches, mailbox
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:16383];
    logic [DATA_W-1:0] last_q;
    logic [1:0] own_q [0:7]; // 0 free, 1 left, 2 right
    logic [7:0] leftPend_q;
    logic semBit_q, semRdPrev_q, memRd, semRd, semSel, live;
    logic [2:0] sa;

    assign sa = pins.addr[2:0];
    assign busyN = !busyForce;
    assign memRd = !pins.chipEnableN && !pins.outputEnableN
        && pins.readWriteN && pins.tokenLatchSelectN;
    // Token select with enable high, or enable-active with all lanes high
    assign semSel = !pins.tokenLatchSelectN
        && (pins.chipEnableN || &pins.byteLaneSelectsN);
    assign semRd = semSel
        && !pins.outputEnableN && pins.readWriteN;
    assign live = (own_q[sa] != 2'd1);

    always_comb begin
        if (!pins.dqOeN)
            dqIn = pins.dq;
        else if (memRd)
            dqIn = mem[pins.addr];
        else if (semRd)
            dqIn = {~last_q[35:9], {9{semRdPrev_q ? semBit_q : live}}};
        else
            dqIn = ~last_q;
    end

    initial begin
        last_q = '0;
        semBit_q = 1'b1;
        semRdPrev_q = 1'b0;
        mailboxIrqN = 1'b1;
        rightIrqN = 1'b1;
        leftPend_q = '0;
        for (int i = 0; i < 16384; i++) mem[i] = '0;
        for (int i = 0; i < 8; i++) own_q[i] = 2'd0;
    end

    always @(posedge mclk) begin
        last_q <= dqIn;
        semRdPrev_q <= semRd;
        // Latched so a right-side change cannot alter a read in flight
        if (semRd) semBit_q <= dqIn[0];
        if (!pins.readWriteN && !pins.chipEnableN) begin
            for (int i = 0; i < LANES; i++) begin
                if (!pins.byteLaneSelectsN[i])
                    mem[pins.addr][9*i +: 9] <= pins.dq[9*i +: 9];
            end
        end
        if (rightMbxWr) mailboxIrqN <= 1'b0;
        // A busy port cannot raise the other side's flag
        if (!pins.readWriteN && !pins.chipEnableN
            && pins.addr == 14'h3FFF && busyN)
            rightIrqN <= 1'b0;
        if (memRd && pins.addr == 14'h3FFE && busyN)
            mailboxIrqN <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            // Right-side requests, whichever select mode that port uses
            if (rightHold[i] && own_q[i] == 2'd0) own_q[i] <= 2'd2;
            if (!rightHold[i] && own_q[i] == 2'd2) begin
                own_q[i] <= leftPend_q[i] ? 2'd1 : 2'd0;
                leftPend_q[i] <= 1'b0;
            end
        end
        if (!pins.readWriteN && semSel) begin
            if (!pins.dq[0] && own_q[sa] == 2'd0)
                own_q[sa] <= 2'd1;
            else if (!pins.dq[0] && own_q[sa] == 2'd2)
                leftPend_q[sa] <= 1'b1;
            else if (pins.dq[0]) begin
                leftPend_q[sa] <= 1'b0;
                if (own_q[sa] == 2'd1) own_q[sa] <= rightHold[sa] ? 2'd2 : 2'd0;
            end
        end
    end
endmodule

// [test_dpa_host_ctrl.sv]
// Purpose: self-checking bench for the dual-port RAM host controller
// Assumes: Wishbone classic master; device model on the pin side
// Notes:   status is polled, the bench never assumes access length
`timescale 1ns/1ps

module test_dpa_host_ctrl
    import dpa_pkg::*;
();
    logic mclk, rst, req, we, ack, busyForce, rightMbxWr, busyN, irqN, rIrqN;
    logic [7:0] adr, rightHold;
    logic [31:0] wdat, rdat, s;
    logic [DATA_W-1:0] dqIn, d;
    dpa_pins_t pins;
    int errors = 0, compares = 0, cycles = 0;

    dpa_host_ctrl dpa_host_ctrl_inst (.mclk(mclk), .rst(rst),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pins(pins), .dqIn(dqIn), .busyN(busyN), .mailboxIrqN(irqN));
    dpa_dev_model dpa_dev_model_inst (.mclk(mclk), .pins(pins),
        .busyForce(busyForce), .rightMbxWr(rightMbxWr),
        .rightHold(rightHold), .dqIn(dqIn), .busyN(busyN),
        .mailboxIrqN(irqN), .rightIrqN(rIrqN));

    // ------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [35:0] e, g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
        @(posedge mclk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        do @(posedge mclk); while (ack !== 1'b1);
        s = rdat;
        req <= 1'b0;
    endtask

    task automatic wait_done;
        s = '0;
        for (int i = 0; i < 300 && !s[ST_DONE]; i++) wb(0, REG_STATUS, 0);
        chk("done", 1, s[ST_DONE]);
    endtask

    task automatic acc(input logic [2:0] op, input logic [13:0] a,
                       input logic [35:0] v, input logic [3:0] ln);
        wb(1, REG_ADDR, {18'h0, a});
        wb(1, REG_WDATA, v[31:0]);
        wb(1, REG_WDATA_HI, {28'h0, v[35:32]});
        wb(1, REG_CTRL, {24'h0, ln, op, 1'b1});
        wait_done;
        wb(0, REG_RDATA, 0);
        d[31:0] = s;
        wb(0, REG_RDATA_HI, 0);
        d[35:32] = s[3:0];
        wb(0, REG_STATUS, 0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        wb(0, REG_CTRL, 0);
        chk("ctrl reset", CTRL_RESET, s);
        wb(0, REG_STATUS, 0);
        chk("status reset", 0, s);
        wb(1, 8'h1C, 32'hFFFF_FFFF);
        wb(0, 8'h1C, 0);
        chk("unmapped", 0, s);
    endtask

    task automatic t_mem;
        acc(OP_MEM_WR, 14'h0123, 36'h9_8765_4321, 4'hF);
        acc(OP_MEM_RD, 14'h0123, 0, 4'hF);
        chk("mem full", 36'h9_8765_4321, d);
        acc(OP_MEM_WR, 14'h0123, 36'h0, 4'h5);
        acc(OP_MEM_RD, 14'h0123, 0, 4'hF);
        chk("mem lanes", 36'h9_8765_4321 & ~36'h0_07FC_01FF, d);
    endtask

    task automatic t_busy;
        busyForce <= 1'b1;
        wb(1, REG_ADDR, 32'h0000_0200);
        wb(1, REG_WDATA, 32'h1111_1111);
        wb(1, REG_CTRL, {24'h0, 4'hF, OP_MEM_WR, 1'b1});
        repeat (30) @(posedge mclk);
        wb(0, REG_STATUS, 0);
        chk("held by busy", 2'b01, s[1:0]);
        busyForce <= 1'b0;
        wait_done;
        chk("busy seen", 1, s[ST_BUSY_SEEN]);
        acc(OP_MEM_RD, 14'h0200, 0, 4'hF);
        chk("busy write", 36'h0_1111_1111, d);
    endtask

    task automatic t_mbox;
        rightMbxWr <= 1'b1;
        @(posedge mclk);
        rightMbxWr <= 1'b0;
        repeat (8) @(posedge mclk);
        wb(0, REG_STATUS, 0);
        chk("irq set", 1, s[ST_MAILBOX]);
        acc(OP_MEM_RD, 14'h3FFF, 0, 4'hF);
        chk("irq kept", 1, s[ST_MAILBOX]);
        acc(OP_MEM_RD, 14'h3FFE, 0, 4'hF);
        repeat (8) @(posedge mclk);
        wb(0, REG_STATUS, 0);
        chk("irq cleared", 0, s[ST_MAILBOX]);
        acc(OP_MEM_WR, 14'h3FFF, 36'h5, 4'hF);
        chk("right irq", 0, rIrqN);
    endtask

    task automatic t_sem;
        acc(OP_SEM_GET, 14'h2AAD, 0, 4'hF);
        chk("token got", 1, s[ST_TOKEN]);
        rightHold <= 8'h20;
        acc(OP_SEM_RD, 14'h0005, 0, 4'hF);
        chk("still held", 9'h000, d[8:0]);
        acc(OP_SEM_WR, 14'h0005, 36'h1, 4'hF);
        acc(OP_SEM_RD, 14'h0005, 0, 4'hF);
        chk("right owns", 9'h1FF, d[8:0]);
        wb(1, REG_CTRL, {24'h0, 4'hF, OP_SEM_GET, 1'b1});
        repeat (80) @(posedge mclk);
        wb(0, REG_STATUS, 0);
        chk("polling", 0, s[ST_DONE]);
        rightHold <= 8'h00;
        wait_done;
        chk("token again", 1, s[ST_TOKEN]);
    endtask

    task automatic close_out;
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        rst = 1'b1;
        req = 1'b0;
        we = 1'b0;
        adr = '0;
        wdat = '0;
        busyForce = 1'b0;
        rightMbxWr = 1'b0;
        rightHold = '0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_mem;
        t_busy;
        t_mbox;
        t_sem;
        close_out;
    end

    // A hang ends in the same report as a normal run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            close_out;
        end
    end
endmodule

bind dpa_host_ctrl dpa_host_properties dpa_host_properties_inst (
    .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .pins(pins), .busyN(busyN));
